/* File: core/clock_out_driver.sv */
`timescale 1ns/1ps
module clock_out_driver (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic drive_clock,
  input wire logic div_clock,
  // Normal pin function
  input wire logic io_out,
  input wire logic io_oe,
  // Pin
  output logic pin_out,
  output logic pin_oe
);

  typedef struct packed {
    logic pin_out;
    logic pin_oe;
  } pin_state_type;

  pin_state_type r;
  pin_state_type r_nxt;

  always_comb begin
    r_nxt = r;
    if (drive_clock) begin
      // Divided clock, overriding the pin
      r_nxt.pin_out = div_clock;
      r_nxt.pin_oe = 1'b1;
    end else begin
      r_nxt.pin_out = io_out;
      r_nxt.pin_oe = io_oe;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Pin stays quiet while reset is active
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign pin_out = r.pin_out;
  assign pin_oe = r.pin_oe;

endmodule

/* File: core/cycle_counter.sv */
`timescale 1ns/1ps
module cycle_counter
  import osc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  input wire logic [15:0] limit,
  input wire logic tick,
  // Result
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] left;
  } cnt_state_type;

  cnt_state_type r;
  cnt_state_type r_nxt;

  always_comb begin
    r_nxt = r;
    r_nxt.done = 1'b0;
    if (start) begin
      r_nxt.left = limit;
      r_nxt.busy = (limit != CK_NONE);
      r_nxt.done = (limit == CK_NONE);
    end else if (r.busy && tick) begin
      // Only edges of the counted source advance the count
      r_nxt.left = r.left - 16'h0001;
      if (r.left == 16'h0001) begin
        r_nxt.busy = 1'b0;
        r_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign busy = r.busy;
  assign done = r.done;

endmodule

/* File: core/oscillator_startup_select.sv */
`timescale 1ns/1ps
// Functional notes
// - Upper select bits give crystal frequency range
// - Crystal lsb0 00/01: 258 cycles, ms extra
// - Crystal 1024-cycle combinations with reset extras
// - Crystal lsb1 01..11: 16384 cycles
// - Two combinations barred when reset pin disabled
// - Low-frequency crystal start-up table, 11 reserved
// - External clock: 6 cycles, reset extras
// - External 00 adds 4 ms if pin disabled
// - Timer may start low-frequency oscillator
// - Timer may enable external clock input
// - Clock output drives the prescaled system clock, overrides pin, unless the crystal is selected
// - No clock output during reset
// - Clock output carries the divided clock
// - Configuration copied into register at reset
// - Millisecond delays timed by watchdog cycles
// - Clock-out bit is inverted configuration bit
module oscillator_startup_select
  import osc_pkg::*;
#(
  parameter int unsigned WDT_LONG_CYCLES = 8192,
  parameter int unsigned XTAL_LONG_CK = 16384,
  parameter int unsigned LF_LONG_CK = 32768
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire apb_req_type apb_req,
  output apb_rsp_type apb_rsp,
  // Non-volatile configuration
  input wire cfg_type cfg,
  // Source and watchdog cycle ticks, prescaled system clock
  input wire logic source_tick,
  input wire logic wdt_tick,
  input wire logic wake_request,
  input wire logic div_clock,
  // Asynchronous timer requests
  input wire logic timer_lf_request,
  input wire logic timer_ext_request,
  // Normal function of the clock output pin
  input wire logic io_out,
  input wire logic io_oe,
  // Oscillator control
  output logic clock_release,
  output logic reset_delay_done,
  output logic xtal_enable,
  output logic [1:0] xtal_range_mode,
  output logic lf_osc_enable,
  output logic external_clock_enable,
  // Clock output pin
  output logic clock_out_pin,
  output logic clock_out_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and state

  typedef enum logic [2:0] {
    PH_LOAD,
    PH_ARM,
    PH_MS,
    PH_CK,
    PH_IDLE
  } phase_type;

  typedef struct packed {
    logic [15:0] ck;
    logic [15:0] reset_ck;
    logic [1:0] ms;
    logic bad;
  } startup_type;

  typedef struct packed {
    phase_type phase;
    clk_sel_type sel;
    apb_rsp_type rsp;
    logic start_ck;
    logic start_ms;
    logic [15:0] ck_limit;
    logic [15:0] ms_limit;
    logic [15:0] pending_ck;
    status_type st;
  } top_state_type;

  localparam logic [15:0] WDT_LONG = WDT_LONG_CYCLES[15:0];
  localparam logic [15:0] XTAL_LONG = XTAL_LONG_CK[15:0];
  localparam logic [15:0] LF_LONG = LF_LONG_CK[15:0];

  top_state_type r;
  top_state_type r_nxt;

  logic ck_busy;
  logic ck_done;
  logic ms_busy;
  logic ms_done;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up table decode

  function automatic startup_type decode_startup(input logic [3:0] src, input logic [1:0] sut, input logic rpd);
    startup_type s;
    s = '{ck: CK_WAKE_SHORT, reset_ck: CK_RESET_EXTRA, ms: MS_NONE, bad: 1'b0};
    if (src[3]) begin
      if (!src[0]) begin
        case (sut)
          2'h0: begin
            s.ck = CK_258;
            s.ms = MS_SHORT;
          end
          2'h1: begin
            s.ck = CK_258;
            s.ms = MS_LONG;
          end
          2'h2: begin
            s.ck = CK_1K;
            s.bad = rpd;
          end
          default: begin
            s.ck = CK_1K;
            s.ms = MS_SHORT;
          end
        endcase
      end else begin
        case (sut)
          2'h0: begin
            s.ck = CK_1K;
            s.ms = MS_LONG;
          end
          2'h1: begin
            s.ck = XTAL_LONG;
            s.bad = rpd;
          end
          2'h2: begin
            s.ck = XTAL_LONG;
            s.ms = MS_SHORT;
          end
          default: begin
            s.ck = XTAL_LONG;
            s.ms = MS_LONG;
          end
        endcase
      end
    end else if (src[3:2] == SRC_LF_PREFIX) begin
      // No source-cycle reset extra for the low-frequency crystal
      s.reset_ck = CK_NONE;
      case (sut)
        2'h0: begin
          s.ck = CK_1K;
          s.ms = MS_SHORT;
        end
        2'h1: begin
          s.ck = CK_1K;
          s.ms = MS_LONG;
        end
        2'h2: begin
          s.ck = LF_LONG;
          s.ms = MS_LONG;
        end
        default: begin
          s.bad = 1'b1;
        end
      endcase
    end else begin
      case (sut)
        2'h0: begin
          // Extra 4 ms only for the external clock
          s.ms = (src == SRC_EXTERNAL && rpd) ? MS_SHORT : MS_NONE;
        end
        2'h1: begin
          s.ms = MS_SHORT;
        end
        2'h2: begin
          s.ms = MS_LONG;
        end
        default: begin
          s.bad = 1'b1;
        end
      endcase
    end
    return s;
  endfunction

  function automatic logic [15:0] ms_cycles(input logic [1:0] ms);
    return (ms == MS_LONG) ? WDT_LONG : WDT_SHORT_CYCLES;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control and register file

  startup_type cur;
  logic access;
  logic write_now;
  logic start_req;
  logic xtal_sel;
  logic lf_sel;
  logic ext_sel;

  always_comb begin
    r_nxt = r;
    r_nxt.start_ck = 1'b0;
    r_nxt.start_ms = 1'b0;
    cur = decode_startup(r.sel.source_select_field, r.sel.startup_select_field, cfg.reset_pin_disable);
    access = apb_req.psel && apb_req.penable;
    write_now = access && apb_req.pwrite && r.rsp.pready;
    start_req = wake_request;

    // One wait state: answer registered, write lands on the completing edge
    if (access && !r.rsp.pready) begin
      r_nxt.rsp.pready = 1'b1;
      r_nxt.rsp.pslverr = 1'b0;
      r_nxt.rsp.prdata = 32'h0000_0000;
      if (apb_req.paddr == ADDR_CLOCK_SELECT) begin
        r_nxt.rsp.prdata = {25'h000_0000, r.sel};
      end else if (apb_req.paddr == ADDR_STATUS) begin
        r_nxt.rsp.prdata = {23'h00_0000, r.st};
      end else if (apb_req.paddr == ADDR_CONTROL) begin
        r_nxt.rsp.prdata = 32'h0000_0000;
      end else begin
        r_nxt.rsp.pslverr = 1'b1;
      end
    end else begin
      r_nxt.rsp.pready = 1'b0;
      r_nxt.rsp.pslverr = 1'b0;
    end

    if (write_now && apb_req.paddr == ADDR_CLOCK_SELECT) begin
      r_nxt.sel = apb_req.pwdata[$bits(clk_sel_type)-1:0];
    end
    if (write_now && apb_req.paddr == ADDR_CONTROL) begin
      start_req = start_req || apb_req.pwdata[CTRL_START_BIT];
    end

    case (r.phase)
      PH_LOAD: begin
        r_nxt.sel.source_select_field = cfg.source_select_config;
        r_nxt.sel.startup_select_field = cfg.startup_select_config;
        r_nxt.sel.clock_out_enable = ~cfg.clock_out_config;
        r_nxt.phase = PH_ARM;
      end
      PH_ARM: begin
        // Reset path: watchdog delay first, then source cycles
        r_nxt.st.reserved_code = cur.bad;
        r_nxt.pending_ck = 16'(cur.ck + cur.reset_ck);
        if (cur.bad) begin
          r_nxt.phase = PH_IDLE;
        end else if (cur.ms != MS_NONE) begin
          r_nxt.start_ms = 1'b1;
          r_nxt.ms_limit = ms_cycles(cur.ms);
          r_nxt.phase = PH_MS;
        end else begin
          r_nxt.start_ck = 1'b1;
          r_nxt.ck_limit = 16'(cur.ck + cur.reset_ck);
          r_nxt.phase = PH_CK;
        end
      end
      PH_MS: begin
        if (ms_done) begin
          r_nxt.start_ck = 1'b1;
          r_nxt.ck_limit = r.pending_ck;
          r_nxt.phase = PH_CK;
        end
      end
      PH_CK: begin
        if (ck_done) begin
          // Release the source only once its count has run out
          r_nxt.st.clock_ready = 1'b1;
          r_nxt.st.reset_delay_done = 1'b1;
          r_nxt.phase = PH_IDLE;
        end
      end
      default: begin
        // Wake-up or availability request: source cycles only
        if (start_req) begin
          r_nxt.st.reserved_code = cur.bad;
          r_nxt.st.clock_ready = 1'b0;
          if (!cur.bad) begin
            r_nxt.start_ck = 1'b1;
            r_nxt.ck_limit = cur.ck;
            r_nxt.phase = PH_CK;
          end
        end
      end
    endcase

    xtal_sel = r.sel.source_select_field[3];
    lf_sel = (r.sel.source_select_field[3:2] == SRC_LF_PREFIX);
    ext_sel = (r.sel.source_select_field == SRC_EXTERNAL);
    r_nxt.st.xtal_enable = xtal_sel;
    // Range mode is the two bits below the crystal marker bit
    r_nxt.st.xtal_range_mode = xtal_sel ? r.sel.source_select_field[2:1] : 2'h0;
    r_nxt.st.lf_osc_enable = lf_sel || (timer_lf_request && (!xtal_sel || !ext_sel));
    r_nxt.st.external_clock_enable = ext_sel || (timer_ext_request && !xtal_sel && !lf_sel);
    r_nxt.st.counting = ck_busy || ms_busy;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{phase: PH_LOAD, default: '0};
    end else begin
      r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters and pin

  cycle_counter source_counter (
    .pclk(pclk),
    .presetn(presetn),
    .start(r.start_ck),
    .limit(r.ck_limit),
    .tick(source_tick),
    .busy(ck_busy),
    .done(ck_done)
  );

  cycle_counter watchdog_counter (
    .pclk(pclk),
    .presetn(presetn),
    .start(r.start_ms),
    .limit(r.ms_limit),
    .tick(wdt_tick),
    .busy(ms_busy),
    .done(ms_done)
  );

  // Held off until the reset delay is over
  logic drive_clock;
  assign drive_clock = r.sel.clock_out_enable && !r.st.xtal_enable && r.st.reset_delay_done;

  clock_out_driver pin_driver (
    .pclk(pclk),
    .presetn(presetn),
    .drive_clock(drive_clock),
    .div_clock(div_clock),
    .io_out(io_out),
    .io_oe(io_oe),
    .pin_out(clock_out_pin),
    .pin_oe(clock_out_oe)
  );

  assign apb_rsp = r.rsp;
  assign clock_release = r.st.clock_ready;
  assign reset_delay_done = r.st.reset_delay_done;
  assign xtal_enable = r.st.xtal_enable;
  assign xtal_range_mode = r.st.xtal_range_mode;
  assign lf_osc_enable = r.st.lf_osc_enable;
  assign external_clock_enable = r.st.external_clock_enable;

endmodule

/* File: shared/osc_pkg.sv */
package osc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [11:0] ADDR_CLOCK_SELECT = 12'h000;
  localparam logic [11:0] ADDR_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // Control register write bits
  localparam int CTRL_START_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Source codes
  localparam logic [3:0] SRC_EXTERNAL = 4'h0;
  localparam logic [1:0] SRC_LF_PREFIX = 2'h1;
  localparam logic [1:0] SUT_RESERVED = 2'h3;

  // Counts in source cycles
  localparam logic [15:0] CK_WAKE_SHORT = 16'h0006;
  localparam logic [15:0] CK_258 = 16'h0102;
  localparam logic [15:0] CK_1K = 16'h0400;
  localparam logic [15:0] CK_RESET_EXTRA = 16'h000E;
  localparam logic [15:0] CK_NONE = 16'h0000;

  // Millisecond delay codes and watchdog-cycle counts
  localparam logic [1:0] MS_NONE = 2'h0;
  localparam logic [1:0] MS_SHORT = 2'h1;
  localparam logic [1:0] MS_LONG = 2'h2;
  localparam logic [15:0] WDT_SHORT_CYCLES = 16'h0200;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic clock_out_enable;
    logic [1:0] startup_select_field;
    logic [3:0] source_select_field;
  } clk_sel_type;

  typedef struct packed {
    logic [3:0] source_select_config;
    logic [1:0] startup_select_config;
    logic clock_out_config;
    logic reset_pin_disable;
  } cfg_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic reserved_code;
    logic [1:0] xtal_range_mode;
    logic xtal_enable;
    logic lf_osc_enable;
    logic external_clock_enable;
    logic reset_delay_done;
    logic clock_ready;
    logic counting;
  } status_type;

endpackage

/* File: sim/osc_startup_properties.sv */
`timescale 1ns/1ps
module osc_startup_properties
  import osc_pkg::*;
#(
  parameter int unsigned WDT_LONG_CYCLES = 8192,
  parameter int unsigned XTAL_LONG_CK = 16384,
  parameter int unsigned LF_LONG_CK = 32768
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Block inputs
  input wire apb_req_type apb_req,
  input wire logic source_tick,
  input wire logic wake_request,
  input wire logic div_clock,
  input wire logic io_out,
  input wire logic io_oe,
  // Block outputs
  input wire apb_rsp_type apb_rsp,
  input wire logic clock_release,
  input wire logic reset_delay_done,
  input wire logic xtal_enable,
  input wire logic [1:0] xtal_range_mode,
  input wire logic external_clock_enable,
  input wire logic clock_out_pin,
  input wire logic clock_out_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence access_s;
    apb_req.psel && apb_req.penable;
  endsequence

  chk_apb_one_wait: assert property (setup_s ##1 access_s |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("ready not after one wait state");
  chk_pin_until_done: assert property (!reset_delay_done |=>
    clock_out_pin == $past(io_out) && clock_out_oe == $past(io_oe))
    else $error("pin left normal function before start-up");
  chk_pin_no_xtal: assert property (clock_out_oe && !$past(io_oe) |-> !$past(xtal_enable))
    else $error("clock driven out while crystal in use");
  chk_pin_divided: assert property (clock_out_oe && !$past(io_oe) |-> clock_out_pin == $past(div_clock))
    else $error("pin not carrying divided clock");
  chk_range_needs_xtal: assert property (xtal_range_mode != 2'h0 |-> xtal_enable)
    else $error("range mode without crystal");
  chk_ext_xtal_excl: assert property (xtal_enable |-> !external_clock_enable)
    else $error("external input shared while crystal runs");
  chk_done_sticky: assert property (reset_delay_done |=> reset_delay_done)
    else $error("reset delay done fell");
  chk_wake_drop: assert property (wake_request && clock_release |-> ##[1:3] !clock_release)
    else $error("release kept after wake");
  chk_release_tick: assert property ($rose(clock_release) |-> $past(source_tick, 2))
    else $error("release not two cycles after a tick");
endmodule

bind oscillator_startup_select osc_startup_properties #(.WDT_LONG_CYCLES(WDT_LONG_CYCLES),
  .XTAL_LONG_CK(XTAL_LONG_CK), .LF_LONG_CK(LF_LONG_CK)) props_inst (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .source_tick(source_tick), .wake_request(wake_request), .div_clock(div_clock),
  .io_out(io_out), .io_oe(io_oe), .apb_rsp(apb_rsp), .clock_release(clock_release),
  .reset_delay_done(reset_delay_done), .xtal_enable(xtal_enable), .xtal_range_mode(xtal_range_mode),
  .external_clock_enable(external_clock_enable), .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe));

/* File: sim/source_model.sv */
`timescale 1ns/1ps
module source_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic run,
  input wire logic slow,
  // Cycle ticks
  output logic source_tick,
  output logic wdt_tick
);
  logic [1:0] phase_r;

  // Resonator-style source, so the lowest range and short counts are legitimate
  // Slow mode leaves gaps so a release can be tied to its last tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'h0;
      source_tick <= 1'b0;
      wdt_tick <= 1'b0;
    end else begin
      phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
      source_tick <= run && (!slow || phase_r == 2'h2);
      wdt_tick <= run;
    end
  end
endmodule

/* File: sim/tb_oscillator_startup_select.sv */
`timescale 1ns/1ps
module tb_oscillator_startup_select
  import osc_pkg::*;
;
  // Short counts keep the run brief
  localparam int WL = 20;
  localparam int XL = 40;
  localparam int LL = 60;
  // Pclk edges beyond the counted ticks: load, arm, counter load, done, flag
  localparam int RST_LAT = 5;
  // Hand-over from the watchdog count to the source count
  localparam int MS_LAT = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_type apb_req = '0;
  apb_rsp_type apb_rsp;
  cfg_type cfg = '0;
  logic wake_request = 1'b0;
  logic div_clock = 1'b0;
  logic timer_lf_request = 1'b0;
  logic timer_ext_request = 1'b0;
  logic io_out = 1'b0;
  logic io_oe = 1'b0;
  logic run = 1'b1;
  logic slow = 1'b0;
  logic source_tick, wdt_tick, clock_release, reset_delay_done, xtal_enable;
  logic lf_osc_enable, external_clock_enable, clock_out_pin, clock_out_oe;
  logic [1:0] xtal_range_mode;
  logic [31:0] q;
  logic e;
  int fails = 0;
  int compares = 0;

  always #25 pclk = ~pclk;
  // Pin function differs from the clock so a wrong source shows
  always @(posedge pclk) begin
    div_clock <= ~div_clock;
    io_out <= div_clock;
  end

  oscillator_startup_select #(.WDT_LONG_CYCLES(WL), .XTAL_LONG_CK(XL), .LF_LONG_CK(LL))
    oscillator_startup_select_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .cfg(cfg), .source_tick(source_tick), .wdt_tick(wdt_tick), .wake_request(wake_request),
    .div_clock(div_clock), .timer_lf_request(timer_lf_request), .timer_ext_request(timer_ext_request),
    .io_out(io_out), .io_oe(io_oe), .clock_release(clock_release), .reset_delay_done(reset_delay_done),
    .xtal_enable(xtal_enable), .xtal_range_mode(xtal_range_mode), .lf_osc_enable(lf_osc_enable),
    .external_clock_enable(external_clock_enable), .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe));

  source_model source_model_inst (.pclk(pclk), .presetn(presetn), .run(run), .slow(slow),
    .source_tick(source_tick), .wdt_tick(wdt_tick));

  ////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // No wait limit here: only the hang guard ends a hung transfer
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge pclk);
  endtask

  task wr_sel(input logic [6:0] v);
    apb(1'b1, ADDR_CLOCK_SELECT, {25'h0, v});
  endtask

  // Counts pclk cycles from release of reset to the end of the start-up
  task reset_run(input cfg_type c, input int exp);
    int n;
    cfg <= c;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (reset_delay_done !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    check(n, exp + RST_LAT);
  endtask

  // Ticks are held off until the request is seen, so every tick counted belongs to it
  task count_run(input logic [6:0] v, input int exp, input logic by_wake);
    int n;
    int k;
    run <= 1'b0;
    slow <= 1'b1;
    wr_sel(v);
    if (by_wake) begin
      wake_request <= 1'b1;
      @(posedge pclk);
      wake_request <= 1'b0;
    end else
      apb(1'b1, ADDR_CONTROL, 32'h0000_0001);
    k = 0;
    while (clock_release !== 1'b0 && k < 10) begin
      @(posedge pclk);
      k++;
    end
    run <= 1'b1;
    n = 0;
    while (clock_release !== 1'b1 && k < 4000) begin
      @(posedge pclk);
      k++;
      if (source_tick === 1'b1)
        n++;
    end
    check(n, exp);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    reset_run('{4'h0, 2'h1, 1'b1, 1'b0}, 512 + 20 + MS_LAT);
    reset_run('{4'h0, 2'h0, 1'b1, 1'b1}, 512 + 20 + MS_LAT);
    reset_run('{4'h4, 2'h0, 1'b1, 1'b0}, 512 + 1024 + MS_LAT);
    reset_run('{4'h8, 2'h0, 1'b1, 1'b0}, 512 + 258 + 14 + MS_LAT);
    reset_run('{4'h8, 2'h2, 1'b1, 1'b0}, 1024 + 14);
    reset_run('{4'h9, 2'h3, 1'b1, 1'b0}, WL + XL + 14 + MS_LAT);
    reset_run('{4'h0, 2'h0, 1'b0, 1'b0}, 20);
    apb(1'b0, ADDR_CLOCK_SELECT, 32'h0);
    check(q, 32'h0000_0040);
    check(clock_out_oe, 1'b1);
    wr_sel(7'h4F);
    repeat (2) @(posedge pclk);
    check(clock_out_oe, 1'b0);
    for (int i = 4; i < 8; i++) begin
      wr_sel({1'b0, 2'h3, i[2:0], 1'b1});
      repeat (2) @(posedge pclk);
      check({xtal_enable, xtal_range_mode}, {1'b1, i[1:0]});
    end
    timer_lf_request <= 1'b1;
    timer_ext_request <= 1'b1;
    wr_sel(7'h02);
    repeat (2) @(posedge pclk);
    check({lf_osc_enable, external_clock_enable}, 2'h3);
    wr_sel(7'h0F);
    repeat (2) @(posedge pclk);
    check(external_clock_enable, 1'b0);
    timer_lf_request <= 1'b0;
    timer_ext_request <= 1'b0;
    count_run(7'h08, 258, 1'b0);
    count_run(7'h28, 1024, 1'b0);
    count_run(7'h09, 1024, 1'b0);
    count_run(7'h19, XL, 1'b0);
    count_run(7'h24, LL, 1'b0);
    count_run(7'h04, 1024, 1'b0);
    count_run(7'h20, 6, 1'b1);
    wr_sel(7'h34);
    apb(1'b1, ADDR_CONTROL, 32'h0000_0001);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({q[8], clock_release}, 2'h2);
    cfg.reset_pin_disable <= 1'b1;
    wr_sel(7'h28);
    apb(1'b1, ADDR_CONTROL, 32'h0000_0001);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(q[8], 1'b1);
    // Same code is legal again with the pin back: flag clears and the count runs
    cfg.reset_pin_disable <= 1'b0;
    apb(1'b1, ADDR_CONTROL, 32'h0000_0001);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({q[8], q[1], q[0]}, 3'h1);
    apb(1'b0, 12'h00C, 32'h0);
    check({e, q}, {1'b1, 32'h0});
    report_and_stop();
  end

  // Hang guard, well beyond the longest expected run
  initial begin
    #3000000;
    fails++;
    report_and_stop();
  end
endmodule
